/* cfg_host.sv */
// Purpose: host model issuing byte accesses to the bank
// Assumes: one-cycle strobes, ack registered at the taking edge and sampled 1 ns after it
// Notes: released address and data are inverted, never left stale
`timescale 1ns/1ps
module cfg_host (
  // clock and answer
  input wire i_clk_sys,
  input wire [7:0] i_rdata,
  input wire i_ack,
  // request
  output reg [7:0] o_addr,
  output reg [7:0] o_wdata,
  output reg o_wr,
  output reg o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = 18'h00000;
  task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q, output k);
    begin
      @(posedge i_clk_sys);
      #1 {o_addr, o_wdata, o_wr, o_rd} = {a, d, w, !w};
      @(posedge i_clk_sys);
      #1 {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'b00};
      q = i_rdata;
      k = i_ack;
    end
  endtask
endmodule

/* cfg_monitor.sv */
// Purpose: port checks on the charger configuration bank
// Assumes: one clock, async active-high reset
// Notes: load cycle after reset release takes no access
`timescale 1ns/1ps
module cfg_monitor (
  input wire i_clk_sys, i_rst, i_reg_wr, i_reg_rd, o_reg_ack,
  input wire [1:0] i_variant, o_trickle_threshold_code, o_ideal_diode_mode, o_system_enable_mode,
  input wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire i_input_supply_present, i_regulator_active, i_system_node_ok,
  input wire i_battery_node_ok, i_batt_above_weak, i_sys_below_batt,
  input wire [2:0] o_term_voltage_code, o_fast_charge_current_code, o_eoc_current_code, o_system_voltage_code,
  input wire [3:0] o_therm_beta_code,
  input wire o_therm_res_select, o_input_disable_mode, o_timer_fault_keep_regulator,
  input wire o_charge_enable, o_battery_monitor_enable,
  input wire o_system_enable_output, o_iso_switch_disable, o_ideal_diode_on
);
  reg live;
  wire mapped = (i_reg_addr == 8'h03) || (i_reg_addr == 8'h05) || (i_reg_addr == 8'h06) ||
    (i_reg_addr == 8'h07) || (i_reg_addr == 8'h08) || (i_reg_addr == 8'h11);
  // ----------------------------------------
  // helper: first edge after release only loads
  // ----------------------------------------
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst)
      live <= 1'b0;
    else
      live <= 1'b1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_reset_defaults: assert property (disable iff (1'b0) i_rst |-> o_fast_charge_current_code == 3'h4
    && o_system_voltage_code == 3'h7 && !o_charge_enable && o_system_enable_mode == 2'h0)
    else $error("wrong value during reset");
  a_variant_load: assert property (!live |=> o_fast_charge_current_code == ($past(i_variant) == 2'h2 ? 3'h1 : 3'h4)
    && o_eoc_current_code == ($past(i_variant) == 2'h2 ? 3'h2 : 3'h0)
    && o_system_voltage_code == ($past(i_variant) == 2'h1 ? 3'h0 : $past(i_variant) == 2'h2 ? 3'h2 : 3'h7))
    else $error("variant default not loaded");
  a_options_fixed: assert property (live |-> o_term_voltage_code == 3'h0 && o_trickle_threshold_code == 2'h0
    && !o_therm_res_select && o_therm_beta_code == 4'h4 && !o_input_disable_mode && o_timer_fault_keep_regulator)
    else $error("option field off its default");
  a_ack_mapped: assert property (live && (i_reg_wr || i_reg_rd) && mapped |=> o_reg_ack)
    else $error("no ack after mapped access");
  a_ack_refused: assert property (!(live && (i_reg_wr || i_reg_rd) && mapped) |=> !o_reg_ack)
    else $error("ack without mapped access");
  a_unmapped_zero: assert property (live && i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_charge_write: assert property (live && i_reg_wr && i_reg_addr == 8'h07 ##1 !(i_reg_wr && i_reg_addr == 8'h07)
    |=> o_charge_enable == $past(i_reg_wdata[0], 2)) else $error("charge enable not written");
  a_sysen_mode0: assert property ($past(live) && o_system_enable_mode == 2'h0
    |-> o_system_enable_output == $past(i_regulator_active && i_system_node_ok)) else $error("mode 0 output");
  a_sysen_mode1: assert property ($past(live) && o_system_enable_mode == 2'h1
    |-> o_system_enable_output == (o_charge_enable && $past(i_battery_node_ok))) else $error("mode 1 output");
  a_weak_isolate: assert property (o_system_enable_mode == 2'h2 && o_battery_monitor_enable
    && $past(live && !i_input_supply_present && !i_batt_above_weak)
    |-> o_system_enable_output && o_iso_switch_disable) else $error("weak battery not isolated");
  a_diode_off: assert property ($past(live) && o_ideal_diode_mode[1] |-> !o_ideal_diode_on)
    else $error("ideal diode on while disabled");
endmodule
bind charger_config_defaults cfg_monitor mon (.*);

/* charger_cfg_map.vh */
// Purpose: offsets, field positions, reset values of the charger configuration bank
// Assumes: 8-bit registers on the serial register port
// Notes: variant selects which factory defaults apply
`ifndef CHARGER_CFG_MAP_VH
`define CHARGER_CFG_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CHARGE_VOLTAGE_LIMIT_CTRL_CTRL 8'h03
`define OFS_RECHARGE_CTRL 8'h05
`define OFS_WATCHDOG_CTRL 8'h06
`define OFS_FUNC_SETTINGS 8'h07
`define OFS_TEMP_PROF_CTRL 8'h08
`define OFS_SYSTEM_ENABLE_OUTPUT_OUT_CTRL 8'h11

// ----------------------------------------
// field positions
// ----------------------------------------
`define POS_VLIM_SEL_LO 0
`define POS_RECHARGE_DIS 7
`define POS_WATCHDOG_EN 2
`define POS_INPUT_DIS 6
`define POS_BATT_MON_EN 5
`define POS_CHARGE_EN 0
`define POS_TPROF_EN 7
`define POS_TPROF_SEL 6
`define POS_VLIM_EN 5
`define POS_IDEAL_DIODE_LO 3
`define POS_SYSTEM_ENABLE_OUTPUT_MODE_LO 0

// ----------------------------------------
// register reset values
// ----------------------------------------
`define RST_CHARGE_VOLTAGE_LIMIT_CTRL_CTRL 8'h00
`define RST_RECHARGE_CTRL 8'h00
`define RST_WATCHDOG_CTRL 8'h00
`define RST_FUNC_SETTINGS 8'h00
`define RST_TEMP_PROF_CTRL 8'h00
`define RST_SYSTEM_ENABLE_OUTPUT_OUT_CTRL 8'h00

// ----------------------------------------
// factory option defaults
// ----------------------------------------
`define RST_TERM_VOLT 3'h0
`define RST_FAST_CHG_A 3'h4
`define RST_FAST_CHG_B 3'h1
`define RST_EOC_A 3'h0
`define RST_EOC_B 3'h2
`define RST_TRICKLE_THR 2'h0
`define RST_SYS_VOLT_A 3'h7
`define RST_SYS_VOLT_B 3'h0
`define RST_SYS_VOLT_C 3'h2
`define RST_THERM_RES 1'h0
`define RST_THERM_BETA 4'h4
`define RST_INPUT_DIS_MODE 1'h0
`define RST_TIMER_FAULT 1'h1

// ----------------------------------------
// variant and mode codes
// ----------------------------------------
`define VARIANT_A 2'h0
`define VARIANT_B 2'h1
`define VARIANT_C 2'h2
`define SYS_MODE_REG_ACTIVE 2'h0
`define SYS_MODE_BATT_NODE 2'h1
`define SYS_MODE_WEAK_ISO 2'h2
`define SYS_MODE_CHG_WEAK 2'h3
`define DIODE_PLAIN 2'h0
`define DIODE_WEAK_QUAL 2'h1

`endif

/* charger_config_defaults.v */
// Purpose: configuration bank of a single-cell charger: factory options and serial-port control bits
// Assumes: a serial protocol engine presents decoded byte reads and writes, synchronous to i_clk_sys
// Notes: analog status arrives as comparator levels; control outputs come from flip-flops
`timescale 1ns/1ps
`include "charger_cfg_map.vh"

module charger_config_defaults (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // factory variant strap
  input wire [1:0] i_variant,
  // register port from the serial engine
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_ack,
  // analog status levels
  input wire i_input_supply_present,
  input wire i_regulator_active,
  input wire i_system_node_ok,
  input wire i_battery_node_ok,
  input wire i_batt_above_weak,
  input wire i_sys_below_batt,
  // factory option fields
  output reg [2:0] o_term_voltage_code,
  output reg [2:0] o_fast_charge_current_code,
  output reg [2:0] o_eoc_current_code,
  output reg [1:0] o_trickle_threshold_code,
  output reg [2:0] o_system_voltage_code,
  output reg o_therm_res_select,
  output reg [3:0] o_therm_beta_code,
  output reg o_input_disable_mode,
  output reg o_timer_fault_keep_regulator,
  // control bits
  output reg [1:0] o_charge_voltage_limit_select,
  output reg o_recharge_disable,
  output reg o_watchdog_enable,
  output reg o_input_disable_function,
  output reg o_battery_monitor_enable,
  output reg o_charge_enable,
  output reg o_temp_profile_enable,
  output reg o_temp_profile_select,
  output reg o_charge_voltage_limit_enable,
  output reg [1:0] o_ideal_diode_mode,
  output reg [1:0] o_system_enable_mode,
  // derived outputs
  output reg o_system_enable_output,
  output reg o_iso_switch_disable,
  output reg o_ideal_diode_on
);

  // ----------------------------------------
  // register images
  // ----------------------------------------
  reg [7:0] charge_voltage_limit_ctrl;
  reg [7:0] recharge_ctrl;
  reg [7:0] watchdog_ctrl;
  reg [7:0] functional_settings;
  reg [7:0] temperature_profile_ctrl;
  reg [7:0] system_enable_output_ctrl;
  // strap capture: defaults loaded one cycle after release, host held off until then
  reg loaded;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `OFS_CHARGE_VOLTAGE_LIMIT_CTRL_CTRL) || (a == `OFS_RECHARGE_CTRL) ||
        (a == `OFS_WATCHDOG_CTRL) || (a == `OFS_FUNC_SETTINGS) ||
        (a == `OFS_TEMP_PROF_CTRL) || (a == `OFS_SYSTEM_ENABLE_OUTPUT_OUT_CTRL);
    end
  endfunction

  // ----------------------------------------
  // factory option fields
  // ----------------------------------------
  // async reset takes variant-A constants; strap-dependent values follow at the first edge
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      loaded <= 1'b0;
      o_term_voltage_code <= `RST_TERM_VOLT;
      o_fast_charge_current_code <= `RST_FAST_CHG_A;
      o_eoc_current_code <= `RST_EOC_A;
      o_trickle_threshold_code <= `RST_TRICKLE_THR;
      o_system_voltage_code <= `RST_SYS_VOLT_A;
      o_therm_res_select <= `RST_THERM_RES;
      o_therm_beta_code <= `RST_THERM_BETA;
      o_input_disable_mode <= `RST_INPUT_DIS_MODE;
      o_timer_fault_keep_regulator <= `RST_TIMER_FAULT;
    end else if (!loaded) begin
      loaded <= 1'b1;
      case (i_variant)
        `VARIANT_B: begin
          o_fast_charge_current_code <= `RST_FAST_CHG_A;
          o_eoc_current_code <= `RST_EOC_A;
          o_system_voltage_code <= `RST_SYS_VOLT_B;
        end
        `VARIANT_C: begin
          o_fast_charge_current_code <= `RST_FAST_CHG_B;
          o_eoc_current_code <= `RST_EOC_B;
          o_system_voltage_code <= `RST_SYS_VOLT_C;
        end
        default: begin
          o_fast_charge_current_code <= `RST_FAST_CHG_A;
          o_eoc_current_code <= `RST_EOC_A;
          o_system_voltage_code <= `RST_SYS_VOLT_A;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  wire wr_ok = i_reg_wr && loaded;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      charge_voltage_limit_ctrl <= `RST_CHARGE_VOLTAGE_LIMIT_CTRL_CTRL;
      recharge_ctrl <= `RST_RECHARGE_CTRL;
      watchdog_ctrl <= `RST_WATCHDOG_CTRL;
      functional_settings <= `RST_FUNC_SETTINGS;
      temperature_profile_ctrl <= `RST_TEMP_PROF_CTRL;
      system_enable_output_ctrl <= `RST_SYSTEM_ENABLE_OUTPUT_OUT_CTRL;
    end else if (wr_ok) begin
      case (i_reg_addr)
        `OFS_CHARGE_VOLTAGE_LIMIT_CTRL_CTRL: charge_voltage_limit_ctrl <= i_reg_wdata;
        `OFS_RECHARGE_CTRL: recharge_ctrl <= i_reg_wdata;
        `OFS_WATCHDOG_CTRL: watchdog_ctrl <= i_reg_wdata;
        `OFS_FUNC_SETTINGS: functional_settings <= i_reg_wdata;
        `OFS_TEMP_PROF_CTRL: temperature_profile_ctrl <= i_reg_wdata;
        `OFS_SYSTEM_ENABLE_OUTPUT_OUT_CTRL: system_enable_output_ctrl <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // read port and acknowledge
  // ----------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    case (i_reg_addr)
      `OFS_CHARGE_VOLTAGE_LIMIT_CTRL_CTRL: rd_mux = charge_voltage_limit_ctrl;
      `OFS_RECHARGE_CTRL: rd_mux = recharge_ctrl;
      `OFS_WATCHDOG_CTRL: rd_mux = watchdog_ctrl;
      `OFS_FUNC_SETTINGS: rd_mux = functional_settings;
      `OFS_TEMP_PROF_CTRL: rd_mux = temperature_profile_ctrl;
      `OFS_SYSTEM_ENABLE_OUTPUT_OUT_CTRL: rd_mux = system_enable_output_ctrl;
      default: rd_mux = 8'h00;
    endcase
  end

  // unmapped addresses read zero and are not acknowledged
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= loaded && (i_reg_wr || i_reg_rd) && is_mapped(i_reg_addr);
      if (loaded && i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // control bit fan-out
  // ----------------------------------------
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_charge_voltage_limit_select <= 2'h0;
      o_recharge_disable <= 1'b0;
      o_watchdog_enable <= 1'b0;
      o_input_disable_function <= 1'b0;
      o_battery_monitor_enable <= 1'b0;
      o_charge_enable <= 1'b0;
      o_temp_profile_enable <= 1'b0;
      o_temp_profile_select <= 1'b0;
      o_charge_voltage_limit_enable <= 1'b0;
      o_ideal_diode_mode <= 2'h0;
      o_system_enable_mode <= 2'h0;
    end else begin
      o_charge_voltage_limit_select <= charge_voltage_limit_ctrl[`POS_VLIM_SEL_LO +: 2];
      o_recharge_disable <= recharge_ctrl[`POS_RECHARGE_DIS];
      o_watchdog_enable <= watchdog_ctrl[`POS_WATCHDOG_EN];
      o_input_disable_function <= functional_settings[`POS_INPUT_DIS];
      o_battery_monitor_enable <= functional_settings[`POS_BATT_MON_EN];
      o_charge_enable <= functional_settings[`POS_CHARGE_EN];
      o_temp_profile_enable <= temperature_profile_ctrl[`POS_TPROF_EN];
      o_temp_profile_select <= temperature_profile_ctrl[`POS_TPROF_SEL];
      o_charge_voltage_limit_enable <= temperature_profile_ctrl[`POS_VLIM_EN];
      o_ideal_diode_mode <= temperature_profile_ctrl[`POS_IDEAL_DIODE_LO +: 2];
      o_system_enable_mode <= system_enable_output_ctrl[`POS_SYSTEM_ENABLE_OUTPUT_MODE_LO +: 2];
    end
  end

  // ----------------------------------------
  // system-enable output and ideal diode
  // ----------------------------------------
  wire chg_en = functional_settings[`POS_CHARGE_EN];
  wire bmon_en = functional_settings[`POS_BATT_MON_EN];
  wire [1:0] sys_mode = system_enable_output_ctrl[`POS_SYSTEM_ENABLE_OUTPUT_MODE_LO +: 2];
  wire [1:0] diode_mode = temperature_profile_ctrl[`POS_IDEAL_DIODE_LO +: 2];
  // weak-battery mode only meaningful on battery power with the monitor running
  wire weak_mode_live = !i_input_supply_present && bmon_en;
  reg next_system_enable_output;
  reg next_iso_dis;
  reg next_diode;

  always @* begin
    next_system_enable_output = 1'b0;
    next_iso_dis = 1'b0;
    case (sys_mode)
      `SYS_MODE_REG_ACTIVE: next_system_enable_output = i_regulator_active && i_system_node_ok;
      `SYS_MODE_BATT_NODE: next_system_enable_output = chg_en && i_battery_node_ok;
      `SYS_MODE_WEAK_ISO: begin
        if (weak_mode_live && !i_batt_above_weak) begin
          next_system_enable_output = 1'b1;
          next_iso_dis = 1'b1;
        end
      end
      `SYS_MODE_CHG_WEAK: next_system_enable_output = chg_en ? i_batt_above_weak : i_regulator_active;
      default: next_system_enable_output = 1'b0;
    endcase
    case (diode_mode)
      `DIODE_PLAIN: next_diode = i_sys_below_batt;
      `DIODE_WEAK_QUAL: next_diode = i_sys_below_batt && i_batt_above_weak;
      default: next_diode = 1'b0;
    endcase
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_system_enable_output <= 1'b0;
      o_iso_switch_disable <= 1'b0;
      o_ideal_diode_on <= 1'b0;
    end else begin
      o_system_enable_output <= next_system_enable_output;
      o_iso_switch_disable <= next_iso_dis;
      o_ideal_diode_on <= next_diode;
    end
  end

endmodule

/* tb.sv */
// Purpose: self-checking bench for the charger configuration bank
// Assumes: host model drives the register port
// Notes: unused option outputs are watched by the bound checker
`timescale 1ns/1ps
module tb;
  localparam [47:0] OFS = 48'h03_05_06_07_08_11;
  localparam [47:0] SETV = 48'h01_80_04_61_E8_00;
  reg i_clk_sys, i_rst;
  reg [1:0] i_variant;
  reg [5:0] ana;
  wire [7:0] addr, wdata, rdata, ctl;
  wire wr, rd, ack, sys_out, iso, diode_on;
  wire [2:0] fast, eoc, sysv;
  wire [1:0] vsel, dmode;
  integer error_cnt, samples_checked, cyc, v, i, m, c;
  reg [7:0] q;
  reg k, e;
  charger_config_defaults dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_variant(i_variant),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_input_supply_present(ana[0]), .i_regulator_active(ana[1]), .i_system_node_ok(ana[2]),
    .i_battery_node_ok(ana[3]), .i_batt_above_weak(ana[4]), .i_sys_below_batt(ana[5]),
    .o_term_voltage_code(), .o_fast_charge_current_code(fast), .o_eoc_current_code(eoc),
    .o_trickle_threshold_code(), .o_system_voltage_code(sysv), .o_therm_res_select(), .o_therm_beta_code(),
    .o_input_disable_mode(), .o_timer_fault_keep_regulator(), .o_charge_voltage_limit_select(vsel),
    .o_recharge_disable(ctl[7]), .o_watchdog_enable(ctl[6]), .o_input_disable_function(ctl[5]),
    .o_battery_monitor_enable(ctl[4]), .o_charge_enable(ctl[3]), .o_temp_profile_enable(ctl[2]),
    .o_temp_profile_select(ctl[1]), .o_charge_voltage_limit_enable(ctl[0]), .o_ideal_diode_mode(dmode),
    .o_system_enable_mode(), .o_system_enable_output(sys_out), .o_iso_switch_disable(iso),
    .o_ideal_diode_on(diode_on)
  );
  cfg_host host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_ack(ack), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task chk(input [79:0] name, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // hang guard, run needs about 1180 cycles
  // ----------------------------------------
  initial cyc = 0;
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    ana = 6'h00;
    for (v = 0; v < 4; v = v + 1) begin
      #1 i_rst = 1'b1;
      i_variant = v[1:0];
      repeat (4) @(posedge i_clk_sys);
      #1 i_rst = 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk("fast", {5'h00, fast}, v == 2 ? 8'h01 : 8'h04);
      chk("eoc", {5'h00, eoc}, v == 2 ? 8'h02 : 8'h00);
      chk("sysv", {5'h00, sysv}, v == 1 ? 8'h00 : v == 2 ? 8'h02 : 8'h07);
      for (i = 0; i < 6; i = i + 1) begin
        host.acc(1'b0, OFS[8*i +: 8], 8'h00, q, k);
        chk("rst_reg", q, 8'h00);
      end
    end
    $display("test variant defaults done");
    for (i = 0; i < 6; i = i + 1) begin
      host.acc(1'b1, OFS[8*i +: 8], 8'hA5 ^ i[7:0], q, k);
      chk("wr_ack", {7'h00, k}, 8'h01);
      host.acc(1'b0, OFS[8*i +: 8], 8'h00, q, k);
      chk("readback", q, 8'hA5 ^ i[7:0]);
    end
    host.acc(1'b1, 8'h04, 8'hFF, q, k);
    chk("unmap_ack", {7'h00, k}, 8'h00);
    host.acc(1'b0, 8'h04, 8'h00, q, k);
    chk("unmap_rd", q, 8'h00);
    for (i = 0; i < 6; i = i + 1)
      host.acc(1'b1, OFS[8*i +: 8], SETV[8*i +: 8], q, k);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("ctl", ctl, 8'hFF);
    chk("vsel_diode", {4'h0, vsel, dmode}, 8'h05);
    $display("test register access done");
    for (c = 0; c < 2; c = c + 1) begin
      host.acc(1'b1, 8'h07, c ? 8'h21 : 8'h20, q, k);
      for (m = 0; m < 4; m = m + 1) begin
        host.acc(1'b1, 8'h11, m[7:0], q, k);
        host.acc(1'b1, 8'h08, {3'h0, m[1:0], 3'h0}, q, k);
        for (i = 0; i < 64; i = i + 1) begin
          ana = i[5:0];
          repeat (2) @(posedge i_clk_sys);
          #1;
          case (m)
            0: e = ana[1] & ana[2];
            1: e = c[0] & ana[3];
            2: e = !ana[4] && !ana[0];
            default: e = c[0] ? ana[4] : ana[1];
          endcase
          chk("system_enable_output", {7'h00, sys_out}, {7'h00, e});
          chk("iso", {7'h00, iso}, {7'h00, m == 2 && e});
          chk("diode", {7'h00, diode_on}, {7'h00, m < 2 && ana[5] && (m == 0 || ana[4])});
        end
      end
    end
    $display("test system enable done");
    end_sim;
  end
endmodule
